// ==== pkg/drc_params.svh ====
// timing figures and field layout for the page-mode dram strobe controller
`ifndef DRC_PARAMS_SVH
`define DRC_PARAMS_SVH

// ----------------------------------------------------------------
// clock and conversion helpers
// ----------------------------------------------------------------
`define DRC_CLK_MHZ        50
// least time in ns to whole cycles, rounded up, never below one
`define DRC_CYC_UP(ns)     ((((ns) * `DRC_CLK_MHZ) + 999) / 1000 + (((ns) == 0) ? 1 : 0))
`define DRC_MAX(a, b)      (((a) > (b)) ? (a) : (b))

// ----------------------------------------------------------------
// address and data layout
// ----------------------------------------------------------------
`define DRC_PIN_AW         9
`define DRC_ADDR_W         18
`define DRC_DATA_W         4
`define DRC_ROW_MSB        17
`define DRC_ROW_LSB        9
`define DRC_COL_MSB        8
`define DRC_COL_LSB        0
`define DRC_INIT_CYCLES    8
`define DRC_SYNC_LAT       3

// ----------------------------------------------------------------
// long times, in their own units
// ----------------------------------------------------------------
`define DRC_POWERUP_US     200
`define DRC_IDLE_MS        8
`define DRC_POWERUP_CYC    (`DRC_POWERUP_US * `DRC_CLK_MHZ)
`define DRC_IDLE_CYC       (`DRC_IDLE_MS * 1000 * `DRC_CLK_MHZ)

// ----------------------------------------------------------------
// strobe times in ns
// ----------------------------------------------------------------
`define DRC_ROW_TO_COLUMN_DELAY_NS  20
`define DRC_ROW_ACTIVE_MIN_NS       70
`define DRC_COLUMN_ACTIVE_MIN_NS    20
`define DRC_ROW_PRECHARGE_TIME_NS   50
`define DRC_ROW_ACCESS_TIME_NS      70
`define DRC_GATE_TURNOFF_DELAY_NS   20
`define DRC_WRITE_TO_ROW_LEAD_NS    20
`define DRC_WRITE_TO_COLUMN_LEAD_NS 20
`define DRC_COLUMN_TO_WRITE_DELAY_NS 50
`define DRC_READ_COMMAND_SETUP_NS   0

// ----------------------------------------------------------------
// derived cycle counts
// ----------------------------------------------------------------
`define DRC_RCD_CYC  `DRC_CYC_UP(`DRC_ROW_TO_COLUMN_DELAY_NS)
`define DRC_RAS_CYC  `DRC_CYC_UP(`DRC_ROW_ACTIVE_MIN_NS)
`define DRC_CAS_CYC  `DRC_CYC_UP(`DRC_COLUMN_ACTIVE_MIN_NS)
`define DRC_RP_CYC   `DRC_CYC_UP(`DRC_ROW_PRECHARGE_TIME_NS)
`define DRC_ACC_CYC  (`DRC_CYC_UP(`DRC_ROW_ACCESS_TIME_NS) + `DRC_SYNC_LAT)
`define DRC_GZ_CYC   `DRC_CYC_UP(`DRC_GATE_TURNOFF_DELAY_NS)
`define DRC_WL_CYC   `DRC_MAX(`DRC_CYC_UP(`DRC_WRITE_TO_ROW_LEAD_NS), \
                              `DRC_CYC_UP(`DRC_WRITE_TO_COLUMN_LEAD_NS))
`define DRC_CWD_CYC  `DRC_CYC_UP(`DRC_COLUMN_TO_WRITE_DELAY_NS)
`define DRC_CASW_CYC `DRC_MAX(`DRC_CAS_CYC, `DRC_CWD_CYC)
`define DRC_RCS_CYC  `DRC_CYC_UP(`DRC_READ_COMMAND_SETUP_NS)

`endif

// ==== pkg/drc_pkg.sv ====
// types shared by the dram strobe controller
package drc_pkg;

  // ----------------------------------------------------------------
  // access kinds on the user port
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DRC_OP_READ  = 2'h0,  // normal read
    DRC_OP_EWR   = 2'h1,  // early write
    DRC_OP_LWR   = 2'h2,  // late, output-enable controlled write
    DRC_OP_RMW   = 2'h3   // read then write, same location
  } drc_op_t;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DRC_S_PWR  = 4'h0,  // power-up pause
    DRC_S_IRAS = 4'h1,  // init/wake row strobe low
    DRC_S_IPRE = 4'h2,  // init/wake precharge
    DRC_S_IDLE = 4'h3,  // waiting for a request
    DRC_S_ASET = 4'h4,  // row address set up
    DRC_S_ROW  = 4'h5,  // row strobe low, multiplex window
    DRC_S_COL  = 4'h6,  // column strobe low
    DRC_S_GOFF = 4'h7,  // output enable released before driving
    DRC_S_WDRV = 4'h8,  // write data on the pins
    DRC_S_WEL  = 4'h9,  // write enable low, lead time
    DRC_S_END  = 4'hA,  // wait for row active minimum
    DRC_S_PRE  = 4'hB   // precharge
  } drc_state_t;

endpackage

// ==== hw/drc_sync.sv ====
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module drc_sync #(
  parameter int W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  // ----------------------------------------------------------------
  // flop chain
  // ----------------------------------------------------------------
  logic [W-1:0] s1;  // first stage, read only by s2
  logic [W-1:0] s2;  // second stage
  logic [W-1:0] s3;  // third stage

  // agreement between stage two and three
  wire  [W-1:0] agree = ~(s2 ^ s3);

  // shift and accept agreed bits
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= (agree & s3) | (~agree & dout);
    end
  end

endmodule

// ==== hw/drc_timer.sv ====
// loadable down counter that flags when it has run out
`timescale 1ns/1ns
module drc_timer #(
  parameter int TW = 20
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          load,
  input  wire logic [TW-1:0] load_val,
  output logic               done
);

  // ----------------------------------------------------------------
  // count register
  // ----------------------------------------------------------------
  logic [TW-1:0] cnt;  // cycles still to run

  // run out when the count is zero and no load is pending
  assign done = (cnt == '0) && !load;

  // load, or count down to zero and stay
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= load_val;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

endmodule

// ==== hw/drc_ctrl.sv ====
// host controller that sequences strobes, address and data of a page-mode dram
//
// Contract
// - wait 200 us, then eight row strobes
// - idle over 8 ms: eight wake-up row strobes
// - row strobe first, column after row-to-column delay
// - write-enable high before column strobe for reads
// - both strobes held their minimum active widths
// - row strobe high for precharge time
// - write-enable high through read and after
// - strobes held write lead times after write
// - late write-enable may lag, within row active
// - read-write reads, then writes the same location
`timescale 1ns/1ns
`include "drc_params.svh"
module drc_ctrl #(
  parameter int POWERUP_CYC = `DRC_POWERUP_CYC,
  parameter int IDLE_CYC    = `DRC_IDLE_CYC,
  parameter int AW          = `DRC_ADDR_W,
  parameter int DW          = `DRC_DATA_W
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  // user side
  input  wire logic                    req,
  input  wire logic [1:0]              req_op,
  input  wire logic [AW-1:0]           req_addr,
  input  wire logic [DW-1:0]           req_wdata,
  output logic                         req_ready,
  output logic [DW-1:0]                rd_data,
  output logic                         rd_valid,
  output logic                         init_done,
  // dram pins
  output logic                         ras_n,
  output logic                         cas_n,
  output logic                         we_n,
  output logic                         oe_n,
  output logic [`DRC_PIN_AW-1:0]       mem_addr,
  output logic [DW-1:0]                dq_out,
  output logic                         dq_oe_n,
  input  wire logic [DW-1:0]           dq_in
);

  // ----------------------------------------------------------------
  // widths and cycle constants
  // ----------------------------------------------------------------
  localparam int TW = $clog2(`DRC_MAX(POWERUP_CYC, IDLE_CYC) + 2);
  localparam logic [TW-1:0] PWR_T  = TW'(POWERUP_CYC);
  localparam logic [TW-1:0] IDLE_T = TW'(IDLE_CYC);
  localparam logic [TW-1:0] RCD_T  = TW'(`DRC_MAX(`DRC_RCD_CYC, `DRC_RCS_CYC));
  localparam logic [TW-1:0] RAS_T  = TW'(`DRC_RAS_CYC);
  localparam logic [TW-1:0] RP_T   = TW'(`DRC_RP_CYC);
  localparam logic [TW-1:0] ACC_T  = TW'(`DRC_MAX(`DRC_ACC_CYC, `DRC_CAS_CYC));
  localparam logic [TW-1:0] CASW_T = TW'(`DRC_CASW_CYC);
  localparam logic [TW-1:0] GZ_T   = TW'(`DRC_GZ_CYC);
  localparam logic [TW-1:0] WL_T   = TW'(`DRC_WL_CYC);
  localparam logic [3:0]    INIT_N = 4'(`DRC_INIT_CYCLES);

  // ----------------------------------------------------------------
  // state and held request
  // ----------------------------------------------------------------
  drc_pkg::drc_state_t state;      // sequencer state
  drc_pkg::drc_op_t    op;         // kind of access in progress
  logic [AW-1:0]       addr;       // latched word address
  logic [3:0]          init_cnt;   // row strobes still to give
  logic [TW-1:0]       idle_cnt;   // cycles spent waiting in idle
  logic                step_load;  // load pulse for the step timer
  logic [TW-1:0]       step_val;   // value loaded into the step timer
  logic                ras_load;   // load pulse for the row active timer
  wire                 step_done;  // step timer ran out
  wire                 ras_done;   // row active minimum satisfied
  wire  [DW-1:0]       dq_sync;    // read data after synchroniser

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  wire take      = req && req_ready;                              // request accepted
  wire idle_sat  = (idle_cnt == IDLE_T);                          // idle too long
  wire step_ok   = step_done && !step_load;                       // wait over
  wire ras_ok    = ras_done && !ras_load;                         // row width met
  wire op_is_ewr = (op == drc_pkg::DRC_OP_EWR);                   // early write
  wire op_reads  = (op == drc_pkg::DRC_OP_READ) ||
                   (op == drc_pkg::DRC_OP_RMW);                   // needs read data
  wire new_ewr   = (drc_pkg::drc_op_t'(req_op) == drc_pkg::DRC_OP_EWR);
  wire [`DRC_PIN_AW-1:0] row_f = addr[`DRC_ROW_MSB:`DRC_ROW_LSB];
  wire [`DRC_PIN_AW-1:0] col_f = addr[`DRC_COL_MSB:`DRC_COL_LSB];
  wire [`DRC_PIN_AW-1:0] new_row = req_addr[`DRC_ROW_MSB:`DRC_ROW_LSB];

  // ----------------------------------------------------------------
  // timers and input synchroniser
  // ----------------------------------------------------------------
  // per-state waits
  drc_timer #(
    .TW       (TW)
  ) u_step (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (step_load),
    .load_val (step_val),
    .done     (step_done)
  );

  // row active minimum, started at each row strobe fall
  drc_timer #(
    .TW       (TW)
  ) u_ras (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (ras_load),
    .load_val (RAS_T),
    .done     (ras_done)
  );

  // data pins come from outside the clock domain
  drc_sync #(
    .W        (DW)
  ) u_dq_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      (dq_in),
    .dout     (dq_sync)
  );

  // ----------------------------------------------------------------
  // idle watch: counts while the sequencer rests in idle
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      idle_cnt <= '0;
    end else if (state != drc_pkg::DRC_S_IDLE) begin
      idle_cnt <= '0;                           // any state but idle restarts the watch
    end else if (!idle_sat) begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state     <= drc_pkg::DRC_S_PWR;
      op        <= drc_pkg::DRC_OP_READ;
      addr      <= '0;
      init_cnt  <= 4'h0;
      step_load <= 1'b1;                        // start the power-up pause
      step_val  <= PWR_T;
      ras_load  <= 1'b0;
      req_ready <= 1'b0;
      rd_data   <= '0;
      rd_valid  <= 1'b0;
      init_done <= 1'b0;
      ras_n     <= 1'b1;
      cas_n     <= 1'b1;
      we_n      <= 1'b1;
      oe_n      <= 1'b1;
      mem_addr  <= '0;
      dq_out    <= '0;
      dq_oe_n   <= 1'b1;
    end else begin
      // pulses default low
      step_load <= 1'b0;
      ras_load  <= 1'b0;
      rd_valid  <= 1'b0;
      case (state)
        // power-up pause, then the row strobe train
        drc_pkg::DRC_S_PWR: begin
          if (step_ok) begin
            init_cnt <= INIT_N;
            ras_n    <= 1'b0;
            ras_load <= 1'b1;
            state    <= drc_pkg::DRC_S_IRAS;
          end
        end
        // one row strobe of the init or wake train
        drc_pkg::DRC_S_IRAS: begin
          if (ras_ok) begin
            ras_n     <= 1'b1;
            init_cnt  <= init_cnt - 1'b1;
            step_load <= 1'b1;
            step_val  <= RP_T;
            state     <= drc_pkg::DRC_S_IPRE;
          end
        end
        // precharge between train strobes
        drc_pkg::DRC_S_IPRE: begin
          if (step_ok) begin
            if (init_cnt == 4'h0) begin
              init_done <= 1'b1;
              req_ready <= 1'b1;
              state     <= drc_pkg::DRC_S_IDLE;
            end else begin
              ras_n    <= 1'b0;
              ras_load <= 1'b1;
              state    <= drc_pkg::DRC_S_IRAS;
            end
          end
        end
        // wait for work; a long rest forces a wake train first
        drc_pkg::DRC_S_IDLE: begin
          if (idle_sat) begin
            req_ready <= 1'b0;
            init_cnt  <= INIT_N;
            ras_n     <= 1'b0;
            ras_load  <= 1'b1;
            state     <= drc_pkg::DRC_S_IRAS;
          end else if (take) begin
            req_ready <= 1'b0;
            op        <= drc_pkg::drc_op_t'(req_op);
            addr      <= req_addr;
            mem_addr  <= new_row;               // row field set up before the strobe
            dq_out    <= req_wdata;
            we_n      <= !new_ewr;
            dq_oe_n   <= !new_ewr;              // early write data ready at column fall
            state     <= drc_pkg::DRC_S_ASET;
          end
        end
        // row strobe falls on the settled row field
        drc_pkg::DRC_S_ASET: begin
          ras_n     <= 1'b0;
          ras_load  <= 1'b1;
          step_load <= 1'b1;
          step_val  <= RCD_T;
          state     <= drc_pkg::DRC_S_ROW;
        end
        // multiplex window: swap to the column field after the row hold
        drc_pkg::DRC_S_ROW: begin
          mem_addr <= col_f;
          if (step_ok) begin
            cas_n     <= 1'b0;
            oe_n      <= !op_reads;
            step_load <= 1'b1;
            step_val  <= op_reads ? ACC_T : CASW_T;
            state     <= drc_pkg::DRC_S_COL;
          end
        end
        // column strobe low: read data arrives, or early write completes
        drc_pkg::DRC_S_COL: begin
          if (step_ok) begin
            if (op_reads) begin
              rd_data  <= dq_sync;
              rd_valid <= 1'b1;
            end
            if (op_is_ewr) begin
              step_load <= 1'b1;
              step_val  <= WL_T;
              state     <= drc_pkg::DRC_S_WEL;
            end else if (op == drc_pkg::DRC_OP_READ) begin
              state <= drc_pkg::DRC_S_END;
            end else begin
              oe_n      <= 1'b1;
              step_load <= 1'b1;
              step_val  <= GZ_T;
              state     <= drc_pkg::DRC_S_GOFF;
            end
          end
        end
        // let the device outputs float before driving the bus
        drc_pkg::DRC_S_GOFF: begin
          if (step_ok) begin
            dq_oe_n <= 1'b0;
            state   <= drc_pkg::DRC_S_WDRV;
          end
        end
        // data stands one cycle before write-enable falls
        drc_pkg::DRC_S_WDRV: begin
          we_n      <= 1'b0;
          step_load <= 1'b1;
          step_val  <= WL_T;
          state     <= drc_pkg::DRC_S_WEL;
        end
        // strobes stay low for the write lead times
        drc_pkg::DRC_S_WEL: begin
          if (step_ok) begin
            state <= drc_pkg::DRC_S_END;
          end
        end
        // release both strobes once the row active minimum is met
        drc_pkg::DRC_S_END: begin
          if (ras_ok) begin
            ras_n     <= 1'b1;
            cas_n     <= 1'b1;
            oe_n      <= 1'b1;
            step_load <= 1'b1;
            step_val  <= RP_T;
            state     <= drc_pkg::DRC_S_PRE;
          end
        end
        // write-enable and data released after the strobes rise
        drc_pkg::DRC_S_PRE: begin
          we_n    <= 1'b1;
          dq_oe_n <= 1'b1;
          if (step_ok) begin
            req_ready <= 1'b1;
            state     <= drc_pkg::DRC_S_IDLE;
          end
        end
        default: begin
          ras_n     <= 1'b1;
          cas_n     <= 1'b1;
          we_n      <= 1'b1;
          oe_n      <= 1'b1;
          dq_oe_n   <= 1'b1;
          req_ready <= 1'b0;
          state     <= drc_pkg::DRC_S_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== tb/drc_chk_assertions.sv ====
// concurrent checks on the dram strobe controller pins
`timescale 1ns/1ns
module drc_chk #(
  parameter int POWERUP_CYC = 20,
  parameter int IDLE_CYC    = 200
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       rd_valid,
  input wire logic       init_done,
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       we_n,
  input wire logic       oe_n,
  input wire logic [8:0] mem_addr,
  input wire logic       dq_oe_n
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic [31:0] cyc;   // cycles since reset release
  logic [31:0] hi;    // cycles row strobe has stayed high
  logic [3:0]  nras;  // row strobe falls since reset
  logic [3:0]  wake;  // ras-only cycles still owed
  logic        ras_q; // row strobe one cycle back
  wire         fall = ras_q && !ras_n;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // counters restart with every reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cyc   <= 32'h0;
      hi    <= 32'h0;
      nras  <= 4'h0;
      wake  <= 4'h0;
      ras_q <= 1'b1;
    end else begin
      ras_q <= ras_n;
      cyc   <= (cyc == 32'hFFFFFFFF) ? cyc : cyc + 32'h1;
      hi    <= ras_n ? hi + 32'h1 : 32'h0;
      nras  <= (fall && nras != 4'hF) ? nras + 4'h1 : nras;
      if (fall) begin
        wake <= (hi > IDLE_CYC) ? 4'h7 : ((wake != 4'h0) ? wake - 4'h1 : 4'h0);
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_powerup_pause: assert property (fall && nras == 4'h0 |-> cyc >= POWERUP_CYC)
    else $error("row strobe before power-up pause ended");
  a_init_count: assert property ($rose(init_done) |-> nras >= 4'h8)
    else $error("fewer than eight init row strobes");
  a_init_ras_only: assert property (!init_done |-> cas_n)
    else $error("column strobe during init train");
  a_wake_ras_only: assert property (wake != 4'h0 |-> cas_n)
    else $error("column strobe inside wake train");
  a_row_first: assert property ($fell(cas_n) |-> $past(!ras_n))
    else $error("column strobe without row delay");
  a_addr_stable: assert property ($fell(ras_n) || $fell(cas_n) |-> $stable(mem_addr))
    else $error("address moved at strobe fall");
  a_ras_width: assert property ($fell(ras_n) |-> !ras_n [*4])
    else $error("row strobe low too short");
  a_precharge_time: assert property ($rose(ras_n) |-> ras_n [*3])
    else $error("row precharge too short");
  a_read_setup: assert property ($fell(cas_n) && we_n |-> $past(we_n))
    else $error("write enable not set up for read");
  a_read_hold: assert property ($rose(ras_n) && we_n |=> we_n)
    else $error("write enable fell after read");
  a_write_lead: assert property (!we_n && !cas_n && ($fell(we_n) || $fell(cas_n))
    |=> !ras_n && !cas_n)
    else $error("strobes released inside write lead");
  a_cwd_wait: assert property ($fell(we_n) && !cas_n |-> $past(!cas_n, 3))
    else $error("late write before column to write delay");
  a_no_contend: assert property (!dq_oe_n |-> oe_n)
    else $error("controller drives data with gate low");
  c_early: cover property ($fell(cas_n) && !we_n);
  c_late: cover property ($fell(we_n) && !cas_n);
  c_read: cover property (rd_valid);
  c_wake: cover property (wake == 4'h7);
endmodule
bind drc_ctrl drc_chk #(.POWERUP_CYC(POWERUP_CYC), .IDLE_CYC(IDLE_CYC)) drc_chk_i (
  .core_clk(core_clk), .rst_n(rst_n), .rd_valid(rd_valid), .init_done(init_done),
  .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .mem_addr(mem_addr),
  .dq_oe_n(dq_oe_n));

// ==== tb/drc_dram_model.sv ====
// behavioural page-mode dram seen from its pins
`timescale 1ns/1ns
module drc_dram_model (
  input  wire logic       ras_n,
  input  wire logic       cas_n,
  input  wire logic       we_n,
  input  wire logic       oe_n,
  input  wire logic [8:0] addr,
  input  wire logic [3:0] dq_in,
  output logic      [3:0] dq_q,
  output logic            dq_drv
);
  logic [3:0]  mem [0:262143];
  logic [8:0]  row;            // latched row field
  logic [17:0] loc;            // selected location
  logic        early  = 1'b0;  // cycle is an early write
  logic        acc_ok = 1'b0;  // row access time has run
  // row field on the row strobe fall, access timer started
  always @(negedge ras_n) begin
    row = addr;
    acc_ok = 1'b0;
    acc_ok <= #70 1'b1;
  end
  always @(posedge ras_n) begin
    acc_ok = 1'b0;
    early = 1'b0;
  end
  // column gated by the internal row strobe; early write samples here
  always @(negedge cas_n) begin
    if (!ras_n) begin
      loc = {row, addr};
      early = !we_n;
      if (!we_n) mem[loc] = dq_in;
    end
  end
  // late write and read-write sample on the write fall
  always @(negedge we_n) begin
    if (!ras_n && !cas_n && !early) mem[loc] = dq_in;
  end
  // unlatched output only while column strobe and gate are low
  assign dq_drv = !cas_n && !oe_n && !early;
  // wrong data until the access time has passed
  assign dq_q = acc_ok ? mem[loc] : ~mem[loc];
endmodule

// ==== tb/tb_drc_ctrl.sv ====
// self-checking bench for the dram strobe controller
`timescale 1ns/1ns
module tb_drc_ctrl;
  localparam int PU = 20;  // shortened power-up pause
  localparam int IC = 200; // shortened idle limit
  logic        core_clk, rst_n, req, req_ready, rd_valid, init_done;
  logic        ras_n, cas_n, we_n, oe_n, dq_oe_n, dev_drv, ew_drive;
  logic [1:0]  req_op, cur_op;
  logic [17:0] req_addr, ar;
  logic [3:0]  req_wdata, rd_data, dq_out, dev_q, bus;
  logic [3:0]  pat = 4'h5;          // floating bus pattern
  logic [8:0]  mem_addr;
  logic [31:0] seed;
  int          err_count, total_checks;
  logic [3:0]  ref_mem [0:262143]; // expected contents
  logic [17:0] pool [4];
  // resolved data pins: controller, device, or a changing float
  assign bus = !dq_oe_n ? dq_out : ((dev_drv === 1'b1) ? dev_q : pat);
  drc_ctrl #(.POWERUP_CYC(PU), .IDLE_CYC(IC)) drc_ctrl_i (
    .core_clk(core_clk), .rst_n(rst_n), .req(req), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
    .mem_addr(mem_addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(bus));
  drc_dram_model drc_dram_model_i (
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .addr(mem_addr),
    .dq_in(bus), .dq_q(dev_q), .dq_drv(dev_drv));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // float pattern moves every cycle; device output watched in early writes
  // the watch restarts at every take, so this process is its only driver
  always @(posedge core_clk) begin
    pat <= pat + 4'h1;
    if (req && req_ready) ew_drive <= 1'b0;
    else if (cur_op == 2'h1 && dev_drv === 1'b1) ew_drive <= 1'b1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [3:0] exp_rd(input logic [17:0] a);
    return ref_mem[a];
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      err_count++;
      final_report();
    end
  endtask
  // one access; entered just after a rising edge
  task automatic access(input logic [1:0] op, input logic [17:0] a, input logic [3:0] d);
    logic [3:0] e;
    int         n;
    e = exp_rd(a);
    cur_op = op;
    req = 1'b1;
    req_op = op;
    req_addr = a;
    req_wdata = d;
    n = 0;
    // ready is looked at once settled; the next edge then takes the request
    while (req_ready !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      #1 n++;
    end
    tmo(n, 2000);
    @(posedge core_clk);
    #1 req = 1'b0;
    if (op == 2'h0 || op == 2'h3) begin
      n = 0;
      while (rd_valid !== 1'b1 && n < 200) begin
        @(posedge core_clk);
        #1 n++;
      end
      tmo(n, 200);
      check("rd_data", {28'h0, rd_data}, {28'h0, e});
    end
    if (op != 2'h0) ref_mem[a] = d;
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1 n++;
    end
    tmo(n, 200);
    if (op == 2'h1) check("early write float", {31'h0, ew_drive}, 32'h0);
  endtask
  initial begin
    int n;
    rst_n = 1'b0;
    req = 1'b0;
    req_op = 2'h0;
    req_addr = 18'h0;
    req_wdata = 4'h0;
    cur_op = 2'h0;
    err_count = 0;
    total_checks = 0;
    seed = 32'hDFD267BE;
    pool = '{18'h00000, 18'h3FFFF, 18'h1FE00, 18'h001FF};
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    n = 0;
    while (init_done !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      #1 n++;
    end
    tmo(n, 2000);
    check("ready after init", {31'h0, req_ready}, 32'h1);
    // corner addresses: early write, then every kind on each
    for (int i = 0; i < 4; i++) access(2'h1, pool[i], pool[i][3:0] ^ 4'hA);
    for (int k = 2; k < 6; k++) begin
      for (int i = 0; i < 4; i++) access(k[1:0], pool[i], 4'h3 + i[3:0] + k[3:0]);
    end
    // random locations: write, random kind, read back
    repeat (15) begin
      seed = xs(seed);
      ar = seed[31:14];
      access(2'h1, ar, seed[3:0]);
      repeat (seed[7:4]) @(posedge core_clk);
      #1 access(seed[9:8], ar, seed[13:10]);
      access(2'h0, ar, 4'h0);
    end
    // long idle forces a wake train, data must survive it
    repeat (IC + 100) @(posedge core_clk);
    #1 for (int i = 0; i < 4; i++) access(2'h0, pool[i], 4'h0);
    final_report();
  end
endmodule
